// ==== pkg/plm_pkg.sv ====
`default_nettype none
package plm_pkg;
   localparam int NCELL = 8;
   localparam int NSIG = 16;
   localparam int NCOL = 32;
   localparam int NTERM = 64;
   localparam int TPC = 8;
   // Register offsets, byte addresses on the register bus.
   localparam logic [11:0] CFG_OFS = 12'h000;
   localparam logic [11:0] STATUS_OFS = 12'h004;
   localparam logic [11:0] TERM_BASE = 12'h100;
   localparam logic [11:0] TERM_LAST = 12'h1FC;
   // Configuration word fields.
   localparam int ALLOW_POS = 0;
   localparam int FAMILY_POS = 1;
   localparam int MODE_LSB = 8;
   localparam int POL_LSB = 16;
   // Status word fields.
   localparam int ST_Q_LSB = 0;
   localparam int ST_OE_LSB = 8;
   localparam int ST_OUT_LSB = 16;
   // Values after reset.
   localparam logic ALLOW_RST = 1'h0;
   localparam logic FAMILY_RST = 1'h0;
   localparam logic [7:0] MODE_RST = 8'hFF;
   localparam logic [7:0] POL_RST = 8'h00;
   localparam logic [31:0] TERM_RST = 32'h0000_0000;
   localparam logic [7:0] Q_RST = 8'h00;
   localparam logic CLKP_RST = 1'h1;

   typedef enum logic [1:0] {MODE_REG, MODE_COMB_IO, MODE_COMB_OUT, MODE_INPUT} plm_mode_t;
   typedef enum logic [1:0] {SEL_CFG, SEL_STATUS, SEL_TERM, SEL_NONE} plm_sel_t;

   typedef struct packed {
      logic [11:0] paddr;
      logic psel;
      logic penable;
      logic pwrite;
      logic [31:0] pwdata;
   } plm_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } plm_apb_rsp_t;

   typedef struct packed {
      logic [NTERM-1:0][NCOL-1:0] terms;
      logic global_register_allow_bit;
      logic global_family_select_bit;
      logic [NCELL-1:0] local_mode_bit;
      logic [NCELL-1:0] local_polarity_bit;
      logic [NCELL-1:0] q;
      logic clk_pin_prev;
      logic [NCELL-1:0] io_out;
      logic [NCELL-1:0] io_oe;
      plm_apb_rsp_t rsp;
   } plm_state_t;
endpackage : plm_pkg
`default_nettype wire

// ==== hdl/plm_array.sv ====
// What this block does
// - eight macrocells, four selectable modes each
// - true and inverted inputs feed AND array
// - clock and enable pins double as inputs
// - unconnected product term reads high
// - true plus inverted input gives low
// - registered output enabled by shared enable
// - combinatorial output enabled by term or always
// - dedicated input keeps buffer disabled
// - dedicated input from neighbour, end cells special
// - two global plus sixteen local bits
// - globals select registers and emulated family
// - mode and polarity chosen per macrocell
// - four muxes steered by globals and mode
// - end cells use inverted allow bit
// - registered only for allow 0, family 1
// - registered sums all eight terms, polarity applies
// - flip-flop loads on clock pin rise
// - registered feedback is inverted flip-flop
// - two combinatorial modes supported
// - combinatorial output: eight terms, middle no feedback in simple family
// - combinatorial I/O: seven terms, first enables
// - polarity one active high, zero low
// - power-up clears flops, registered outputs high
`timescale 1ns/1ps
`default_nettype none
module plm_array (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic resetn,
   // Register bus
   input wire plm_pkg::plm_apb_req_t apb_req,
   output var plm_pkg::plm_apb_rsp_t apb_rsp,
   // Dedicated pins
   input wire logic clk_pin,
   input wire logic oe_n_pin,
   input wire logic [7:0] in_pin,
   // Macrocell pins
   input wire logic [7:0] io_in,
   output var logic [7:0] io_out,
   output var logic [7:0] io_oe
);

   plm_pkg::plm_state_t s_q;
   plm_pkg::plm_state_t s_d;
   logic [plm_pkg::NSIG-1:0] sig;
   logic [plm_pkg::NTERM-1:0] pt;
   logic [7:0] sum;
   logic [7:0] fb;
   logic [7:0] d_reg;
   logic [7:0] m_reg;
   logic [7:0] m_io;
   logic [7:0] m_out;
   logic [7:0] m_in;
   logic clk_rise;
   logic setup;
   logic access;
   plm_pkg::plm_sel_t sel;

   function automatic logic pt_eval(input logic [31:0] conn, input logic [15:0] s);
      logic [31:0] col;
      col = 32'h0000_0000;
      for (int k = 0; k < plm_pkg::NSIG; k++) begin
         col[2*k] = s[k];
         col[2*k+1] = ~s[k];
      end
      return &(~conn | col);
   endfunction : pt_eval

   function automatic plm_pkg::plm_mode_t cell_mode(input logic allow, input logic family,
                                                    input logic m);
      plm_pkg::plm_mode_t r;
      if (family && !m && !allow) begin
         r = plm_pkg::MODE_REG;
      end else if (family && m) begin
         r = plm_pkg::MODE_COMB_IO;
      end else if (!m) begin
         r = plm_pkg::MODE_COMB_OUT;
      end else begin
         r = plm_pkg::MODE_INPUT;
      end
      return r;
   endfunction : cell_mode

   function automatic plm_pkg::plm_sel_t decode(input logic [11:0] a);
      plm_pkg::plm_sel_t r;
      if (a == plm_pkg::CFG_OFS) begin
         r = plm_pkg::SEL_CFG;
      end else if (a == plm_pkg::STATUS_OFS) begin
         r = plm_pkg::SEL_STATUS;
      end else if (a >= plm_pkg::TERM_BASE && a <= plm_pkg::TERM_LAST && a[1:0] == 2'h0) begin
         r = plm_pkg::SEL_TERM;
      end else begin
         r = plm_pkg::SEL_NONE;
      end
      return r;
   endfunction : decode

   always_comb begin
      logic allow;
      logic family;
      logic fbsel;
      logic adj;
      allow = s_q.global_register_allow_bit;
      family = s_q.global_family_select_bit;
      fbsel = 1'h0;
      adj = 1'h0;
      m_reg = 8'h00;
      m_io = 8'h00;
      m_out = 8'h00;
      m_in = 8'h00;
      fb = 8'h00;
      for (int x = 0; x < plm_pkg::NCELL; x++) begin
         unique case (cell_mode(allow, family, s_q.local_mode_bit[x]))
            plm_pkg::MODE_REG: m_reg[x] = 1'h1;
            plm_pkg::MODE_COMB_IO: m_io[x] = 1'h1;
            plm_pkg::MODE_COMB_OUT: m_out[x] = 1'h1;
            plm_pkg::MODE_INPUT: m_in[x] = 1'h1;
         endcase
         // Neighbour pin; the two middle cells have none in the simple family.
         if (x == 0) begin
            adj = oe_n_pin;
         end else if (x == 7) begin
            adj = clk_pin;
         end else if (x < 3) begin
            adj = io_in[x-1];
         end else if (x > 4) begin
            adj = io_in[x+1];
         end else begin
            adj = 1'h0;
         end
         fbsel = (x == 0 || x == 7) ? ~allow : family;
         if (!fbsel) begin
            fb[x] = adj;
         end else if (m_reg[x]) begin
            fb[x] = ~s_q.q[x];
         end else begin
            fb[x] = io_in[x];
         end
      end
      sig = {fb, in_pin};
      for (int p = 0; p < plm_pkg::NTERM; p++) begin
         pt[p] = pt_eval(s_q.terms[p], sig);
      end
      for (int x = 0; x < plm_pkg::NCELL; x++) begin
         if (m_io[x]) begin
            sum[x] = |pt[x*plm_pkg::TPC+1 +: 7];
         end else begin
            sum[x] = |pt[x*plm_pkg::TPC +: plm_pkg::TPC];
         end
      end
      d_reg = sum ^ s_q.local_polarity_bit;
   end

   assign clk_rise = clk_pin && !s_q.clk_pin_prev;
   assign setup = apb_req.psel && !apb_req.penable;
   assign access = apb_req.psel && apb_req.penable && s_q.rsp.pready;
   assign sel = decode(apb_req.paddr);

   always_comb begin
      s_d = s_q;
      s_d.clk_pin_prev = clk_pin;
      for (int x = 0; x < plm_pkg::NCELL; x++) begin
         if (m_reg[x] && clk_rise) begin
            s_d.q[x] = d_reg[x];
         end
         if (m_reg[x]) begin
            s_d.io_out[x] = ~s_q.q[x];
            s_d.io_oe[x] = ~oe_n_pin;
         end else if (m_io[x]) begin
            s_d.io_out[x] = sum[x] ^ ~s_q.local_polarity_bit[x];
            s_d.io_oe[x] = pt[x*plm_pkg::TPC];
         end else if (m_out[x]) begin
            s_d.io_out[x] = sum[x] ^ ~s_q.local_polarity_bit[x];
            s_d.io_oe[x] = 1'h1;
         end else begin
            s_d.io_out[x] = 1'h0;
            s_d.io_oe[x] = 1'h0;
         end
      end
      // Zero-wait slave: pready rises in the first access cycle.
      s_d.rsp.pready = setup;
      s_d.rsp.pslverr = setup && (sel == plm_pkg::SEL_NONE);
      s_d.rsp.prdata = 32'h0000_0000;
      if (setup && !apb_req.pwrite) begin
         unique case (sel)
            plm_pkg::SEL_CFG: begin
               s_d.rsp.prdata[plm_pkg::ALLOW_POS] = s_q.global_register_allow_bit;
               s_d.rsp.prdata[plm_pkg::FAMILY_POS] = s_q.global_family_select_bit;
               s_d.rsp.prdata[plm_pkg::MODE_LSB +: 8] = s_q.local_mode_bit;
               s_d.rsp.prdata[plm_pkg::POL_LSB +: 8] = s_q.local_polarity_bit;
            end
            plm_pkg::SEL_STATUS: begin
               s_d.rsp.prdata[plm_pkg::ST_Q_LSB +: 8] = s_q.q;
               s_d.rsp.prdata[plm_pkg::ST_OE_LSB +: 8] = s_q.io_oe;
               s_d.rsp.prdata[plm_pkg::ST_OUT_LSB +: 8] = s_q.io_out;
            end
            plm_pkg::SEL_TERM: s_d.rsp.prdata = s_q.terms[apb_req.paddr[7:2]];
            plm_pkg::SEL_NONE: s_d.rsp.prdata = 32'h0000_0000;
         endcase
      end
      if (access && apb_req.pwrite) begin
         if (sel == plm_pkg::SEL_CFG) begin
            // Changing the word while pins are live gives glitches; load it first.
            s_d.global_register_allow_bit = apb_req.pwdata[plm_pkg::ALLOW_POS];
            s_d.global_family_select_bit = apb_req.pwdata[plm_pkg::FAMILY_POS];
            s_d.local_mode_bit = apb_req.pwdata[plm_pkg::MODE_LSB +: 8];
            s_d.local_polarity_bit = apb_req.pwdata[plm_pkg::POL_LSB +: 8];
         end else if (sel == plm_pkg::SEL_TERM) begin
            s_d.terms[apb_req.paddr[7:2]] = apb_req.pwdata;
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         s_q.terms <= {plm_pkg::NTERM{plm_pkg::TERM_RST}};
         s_q.global_register_allow_bit <= plm_pkg::ALLOW_RST;
         s_q.global_family_select_bit <= plm_pkg::FAMILY_RST;
         s_q.local_mode_bit <= plm_pkg::MODE_RST;
         s_q.local_polarity_bit <= plm_pkg::POL_RST;
         s_q.q <= plm_pkg::Q_RST;
         s_q.clk_pin_prev <= plm_pkg::CLKP_RST;
         s_q.io_out <= 8'h00;
         s_q.io_oe <= 8'h00;
         s_q.rsp <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign apb_rsp = s_q.rsp;
   assign io_out = s_q.io_out;
   assign io_oe = s_q.io_oe;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);

   sequence s_setup;
      apb_req.psel && !apb_req.penable;
   endsequence
   sequence s_cfg_write;
      s_setup ##1 (access && apb_req.pwrite && apb_req.paddr == plm_pkg::CFG_OFS);
   endsequence

   AST_READY_NEXT: assert property (s_setup |=> apb_rsp.pready ##1 !apb_rsp.pready)
      else $error("pready not a single access-cycle pulse");
   AST_CFG_WRITE: assert property (
      s_cfg_write |=> s_q.local_mode_bit == $past(apb_req.pwdata[15:8])
         && s_q.local_polarity_bit == $past(apb_req.pwdata[23:16]))
      else $error("configuration write not stored");
   AST_EMPTY_HIGH: assert property (s_q.terms[0] == 32'h0000_0000 |-> pt[0])
      else $error("empty product term not high");
   AST_CONTRA_LOW: assert property (s_q.terms[1][1:0] == 2'h3 |-> !pt[1])
      else $error("contradicting product term not low");
   AST_REG_OE: assert property (m_reg[2] |=> io_oe[2] == !$past(oe_n_pin))
      else $error("registered enable does not follow enable pin");
   AST_COMB_OE: assert property (m_io[1] |=> io_oe[1] == $past(pt[8]))
      else $error("combinatorial I/O enable not from first term");
   AST_INPUT_OFF: assert property ((m_in & 8'h01) != 8'h00 ##1 1'b1 |-> !io_oe[0])
      else $error("dedicated input drives its pin");
   AST_MC0_FB: assert property (s_q.global_register_allow_bit |-> fb[0] == oe_n_pin)
      else $error("lowest cell feedback not from enable pin");
   AST_REG_LOAD: assert property (clk_rise && m_reg[3] |=> s_q.q[3] == $past(d_reg[3]))
      else $error("flip-flop missed clock pin rise");
   AST_REG_HOLD: assert property (!clk_rise |=> $stable(s_q.q))
      else $error("flip-flop changed without clock pin rise");
   AST_FB_REG: assert property (m_reg[4] |-> fb[4] == !s_q.q[4])
      else $error("registered feedback not inverted flop");
   AST_POWERUP: assert property ($rose(resetn) |-> s_q.q == 8'h00 ##1 io_out == 8'h00)
      else $error("flops not clear after power-up");

   // Term writes are checked word by word, since a wrong index corrupts another cell.
   sequence s_term_write;
      s_setup ##1 (access && apb_req.pwrite && sel == plm_pkg::SEL_TERM);
   endsequence

   // Cell 1 is in exactly one mode for any configuration word.
   AST_MODE_ONE: assert property ($onehot({m_reg[1], m_io[1], m_out[1], m_in[1]}))
      else $error("cell not in exactly one mode");

   // The registered mode needs the allow bit clear and the registered family.
   AST_MODE_REG: assert property (m_reg != 8'h00 |->
      !s_q.global_register_allow_bit && s_q.global_family_select_bit)
      else $error("registered mode under wrong globals");

   // A single true connection passes that input straight through.
   AST_PT_TRUE: assert property (s_q.terms[8] == 32'h0000_0004 |-> pt[8] == in_pin[1])
      else $error("true input connection not passed");

   // Registered pins show the inverted flop one cycle later.
   AST_REG_PIN: assert property (m_reg[5] |=> io_out[5] == !$past(s_q.q[5]))
      else $error("registered pin not inverted flop");

   AST_REG_OE7: assert property (m_reg[7] |=> io_oe[7] == !$past(oe_n_pin))
      else $error("registered enable of highest cell wrong");

   // Any one of the eight terms must reach a registered sum.
   AST_REG_EIGHT: assert property (m_reg[6] && pt[55] |-> sum[6])
      else $error("last term missing from registered sum");

   // The end cells use the allow bit, so registered feedback still reaches them.
   AST_FB_REG0: assert property (m_reg[0] |-> fb[0] == !s_q.q[0])
      else $error("lowest cell registered feedback wrong");

   AST_OUT_EIGHT: assert property (m_out[5] && pt[40] |-> sum[5])
      else $error("first term missing from output sum");

   AST_OUT_OE_ON: assert property (m_out[6] |=> io_oe[6])
      else $error("combinatorial output not always enabled");

   // Polarity one drives the sum, zero its inverse.
   AST_OUT_POL: assert property (m_out[2] |=>
      io_out[2] == ($past(sum[2]) == $past(s_q.local_polarity_bit[2])))
      else $error("output polarity wrong");

   AST_IO_POL: assert property (m_io[3] |=>
      io_out[3] == ($past(sum[3]) == $past(s_q.local_polarity_bit[3])))
      else $error("I/O polarity wrong");

   // The enable term must not leak into the sum of an I/O cell.
   AST_IO_SEVEN: assert property (m_io[5] && pt[40] && !(|pt[47:41]) |-> !sum[5])
      else $error("enable term reaches I/O sum");

   AST_IO_FB: assert property (s_q.global_family_select_bit && m_io[2] |->
      fb[2] == io_in[2])
      else $error("I/O feedback not from own pin");

   AST_INPUT_PIN: assert property (m_in[7] |=> !io_oe[7] && !io_out[7])
      else $error("dedicated input drives highest pin");

   // The two middle cells have no neighbour in the simple family.
   AST_MID_NOFB: assert property (!s_q.global_family_select_bit |->
      fb[3] == 1'b0 && fb[4] == 1'b0)
      else $error("middle cell feedback not quiet");

   AST_MC7_FB: assert property (s_q.global_register_allow_bit |-> fb[7] == clk_pin)
      else $error("highest cell feedback not from clock pin");

   // Unmapped addresses answer with an error and zero data.
   AST_SLVERR: assert property (s_setup && sel == plm_pkg::SEL_NONE |=>
      apb_rsp.pslverr && apb_rsp.prdata == 32'h0000_0000)
      else $error("unmapped access not flagged");

   AST_TERM_WRITE: assert property (s_term_write |=>
      s_q.terms[$past(apb_req.paddr[7:2])] == $past(apb_req.pwdata))
      else $error("term write not stored");
endmodule : plm_array
`default_nettype wire

// ==== testbench/plm_board.sv ====
`timescale 1ns/1ps
`default_nettype none
module plm_board (
   // Macrocell pins as driven by the device
   input wire logic [7:0] io_out,
   input wire logic [7:0] io_oe,
   // Levels the board puts on pins the device has released
   input wire logic [7:0] ext_val,
   // Resolved pin levels
   output logic [7:0] io_in
);
   // The board drives every pin the device leaves alone, so no pin floats.
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         io_in[i] = io_oe[i] ? io_out[i] : ext_val[i];
      end
   end
endmodule : plm_board
`default_nettype wire

// ==== testbench/programmable_logic_macrocell_array_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module programmable_logic_macrocell_array_tb;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   plm_pkg::plm_apb_req_t req = '0;
   plm_pkg::plm_apb_rsp_t apb_rsp;
   logic clk_pin = 1'b0;
   logic oe_n_pin = 1'b1;
   logic [7:0] in_pin = 8'h00;
   logic [7:0] ext_val = 8'h00;
   logic [7:0] io_in;
   logic [7:0] io_out;
   logic [7:0] io_oe;
   logic [31:0] rd;
   logic er;
   logic [7:0] exp_v;
   int miscompares = 0;
   int check_count = 0;
   int cyc = 0;
   int seed_v;

   always #2.5 clk_sys = ~clk_sys;

   plm_array plm_array_inst (.clk_sys(clk_sys), .resetn(resetn), .apb_req(req),
      .apb_rsp(apb_rsp), .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .in_pin(in_pin),
      .io_in(io_in), .io_out(io_out), .io_oe(io_oe));
   plm_board plm_board_inst (.io_out(io_out), .io_oe(io_oe), .ext_val(ext_val), .io_in(io_in));

   task test_done();
      if (miscompares == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : test_done

   always @(posedge clk_sys) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         test_done();
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] expv);
      check_count++;
      if (seen !== expv) begin
         miscompares++;
         $display("MISMATCH t=%0t seen=%h expected=%h", $time, seen, expv);
      end
   endtask : chk

   // The master holds the request until pready is sampled high at an edge.
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      req.psel <= 1'b1;
      req.penable <= 1'b0;
      req.pwrite <= w;
      req.paddr <= a;
      req.pwdata <= d;
      @(posedge clk_sys);
      req.penable <= 1'b1;
      #1;
      while (apb_rsp.pready !== 1'b1) begin
         @(posedge clk_sys);
         #1;
      end
      // The answer stands until the next edge, which completes the transfer.
      rd = apb_rsp.prdata;
      er = apb_rsp.pslverr;
      @(posedge clk_sys);
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask : apb

   // Term 8x is the first term of cell x; the unused terms are forced low.
   task set_terms(input int x, input logic [31:0] t0, input logic [31:0] t1);
      for (int k = 0; k < 8; k++) begin
         apb(1'b1, plm_pkg::TERM_BASE + 12'(32 * x + 4 * k),
            (k == 0) ? t0 : ((k == 1) ? t1 : 32'h0000_0003));
      end
   endtask : set_terms

   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick

   function automatic logic [7:0] rot1(input logic [7:0] v);
      return {v[0], v[7:1]};
   endfunction : rot1

   initial begin
      seed_v = $urandom(11);
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      tick(2);
      chk(io_oe, 8'h00);
      apb(1'b0, plm_pkg::CFG_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_FF00);
      apb(1'b0, plm_pkg::STATUS_OFS, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b0, 12'h008, 32'h0000_0000);
      chk({rd[30:0], er}, 32'h0000_0001);
      // Registered output: each cell samples its own dedicated input.
      for (int x = 0; x < 8; x++) set_terms(x, 32'h1 << (2 * x), 32'h0000_0003);
      apb(1'b1, plm_pkg::CFG_OFS, 32'h00FF_0002);
      tick(3);
      chk(io_out, 8'hFF);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         in_pin <= 8'($urandom());
         oe_n_pin <= 1'($urandom());
         @(posedge clk_sys);
         clk_pin <= 1'b1;
         @(posedge clk_sys);
         clk_pin <= 1'b0;
         exp_v = in_pin;
         tick(3);
         chk(io_out, exp_v);
         chk(io_oe, {8{~oe_n_pin}});
         @(posedge clk_sys);
         in_pin <= ~in_pin;
         tick(4);
         chk(io_out, exp_v);
      end
      apb(1'b0, plm_pkg::STATUS_OFS, 32'h0000_0000);
      chk(rd[7:0], {~exp_v});
      // Combinatorial output in both polarities.
      for (int p = 0; p < 2; p++) begin
         apb(1'b1, plm_pkg::CFG_OFS, {8'h00, {8{p[0]}}, 16'h0001});
         for (int i = 0; i < 6; i++) begin
            @(posedge clk_sys);
            in_pin <= 8'($urandom());
            tick(3);
            chk(io_out, {p[0] ? in_pin : ~in_pin});
            chk(io_oe, 8'hFF);
         end
      end
      // Combinatorial I/O: term 0 enables, term 1 takes the neighbour input, except cell 7 where it is always high.
      for (int x = 0; x < 8; x++) set_terms(x, 32'h1 << (2 * x), 32'h1 << (2 * ((x + 1) % 8)));
      apb(1'b1, plm_pkg::TERM_BASE + 12'h0E4, 32'h0000_0000);
      apb(1'b1, plm_pkg::CFG_OFS, 32'h00FF_FF02);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         in_pin <= 8'($urandom());
         tick(3);
         chk(io_oe, in_pin);
         chk(io_out & io_oe, (rot1(in_pin) | 8'h80) & in_pin);
      end
      // Dedicated inputs on cells 0, 1 and 7 seen through cells 3, 2 and 4.
      set_terms(2, 32'h1 << 18, 32'h0000_0003);
      set_terms(3, 32'h1 << 16, 32'h0000_0003);
      set_terms(4, 32'h1 << 30, 32'h0000_0003);
      apb(1'b1, plm_pkg::CFG_OFS, 32'h001C_8301);
      for (int i = 0; i < 8; i++) begin
         @(posedge clk_sys);
         ext_val <= 8'($urandom());
         oe_n_pin <= 1'($urandom());
         clk_pin <= 1'($urandom());
         tick(3);
         chk(io_out[4:2], {clk_pin, oe_n_pin, ext_val[0]});
         chk(io_oe & 8'h83, 8'h00);
      end
      test_done();
   end
endmodule : programmable_logic_macrocell_array_tb
`default_nettype wire
